// ---- rtl/uda_pkg.sv ----
`default_nettype none
package uda_pkg;
  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_EP_WR_BASE = 8'h20;
  localparam logic [7:0] CMD_EP_RD_BASE = 8'h30;
  localparam logic [7:0] CMD_ADDR_WR    = 8'hB6;
  localparam logic [7:0] CMD_ADDR_RD    = 8'hB7;
  localparam logic [7:0] CMD_MODE_WR    = 8'hB8;
  localparam logic [7:0] CMD_MODE_RD    = 8'hB9;
  localparam logic [7:0] CMD_NONE       = 8'h00;

  // ****************************************************************
  // Register layout and reset values
  // ****************************************************************
  localparam int unsigned NUM_EP          = 16;
  localparam int unsigned EP_IDX_W        = 4;
  localparam int unsigned EP_FIFO_EN_BIT  = 7;
  localparam int unsigned EP_DIR_BIT      = 6;
  localparam int unsigned EP_DBL_BIT      = 5;
  localparam int unsigned EP_ISO_BIT      = 4;
  localparam int unsigned EP_SIZE_LSB     = 0;
  localparam int unsigned EP_SIZE_W       = 4;
  localparam int unsigned ADDR_EN_BIT     = 7;
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned MODE_DBG_BIT    = 2;
  localparam logic [7:0]  EP_CFG_RST      = 8'h00;
  localparam logic [7:0]  ADDR_RST        = 8'h00;
  localparam logic [7:0]  MODE_RST        = 8'h00;
  localparam logic [7:0]  MODE_BUSRST_CLR = 8'h70;
  localparam logic [6:0]  ACTIVE_ADDR_RST = 7'h00;
endpackage
`default_nettype wire

// ---- rtl/uda_addr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface uda_addr_if;
  logic       addr_written;
  logic [7:0] addr_reg;
  logic       bus_reset;
  logic       status_ack;
  logic       token_valid;
  logic [6:0] token_addr;
  logic [6:0] active_addr;
  logic       active_en;
  logic       accept;

  modport cfg  (output addr_written, addr_reg, bus_reset, status_ack, token_valid, token_addr,
                input  active_addr, active_en, accept);
  modport unit (input  addr_written, addr_reg, bus_reset, status_ack, token_valid, token_addr,
                output active_addr, active_en, accept);
endinterface
`default_nettype wire

// ---- rtl/uda_addr_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module uda_addr_unit
  import uda_pkg::*;
(
  input  wire logic ref_clk, // System clock.
  input  wire logic rst_n,   // Asynchronous reset, active low.
  uda_addr_if.unit  bus      // Address register side.
);
  logic [6:0] active_addr;
  logic       active_en;
  logic       pending;
  logic       accept;
  logic [6:0] next_active_addr;
  logic       next_active_en;
  logic       next_pending;
  logic       next_accept;

  always_comb begin
    next_active_addr = active_addr;
    next_active_en   = active_en;
    next_pending     = pending;
    if (bus.status_ack && pending) begin
      next_active_addr = bus.addr_reg[ADDR_W-1:0];
      next_active_en   = bus.addr_reg[ADDR_EN_BIT];
      next_pending     = 1'b0;
    end
    if (bus.bus_reset) begin
      next_active_addr = ACTIVE_ADDR_RST;
      next_active_en   = 1'b1;
      next_pending     = 1'b0;
    end
    if (bus.addr_written) begin
      next_pending = 1'b1;
    end
    next_accept = bus.token_valid && active_en && (bus.token_addr == active_addr);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_addr <= ACTIVE_ADDR_RST;
      active_en   <= 1'b0;
      pending     <= 1'b0;
      accept      <= 1'b0;
    end else begin
      active_addr <= next_active_addr;
      active_en   <= next_active_en;
      pending     <= next_pending;
      accept      <= next_accept;
    end
  end

  assign bus.active_addr = active_addr;
  assign bus.active_en   = active_en;
  assign bus.accept      = accept;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ack_copy;
    pending && bus.status_ack && !bus.bus_reset && !bus.addr_written;
  endsequence

  property p_reset_addr;
    @(posedge ref_clk) disable iff (!rst_n)
      bus.bus_reset |=> (active_addr == 7'h00) && active_en;
  endproperty
  a_reset_addr: assert property (p_reset_addr)
    else $error("bus reset did not clear the working address");

  property p_hold_old;
    @(posedge ref_clk) disable iff (!rst_n)
      (!bus.status_ack && !bus.bus_reset) |=> $stable(active_addr) && $stable(active_en);
  endproperty
  a_hold_old: assert property (p_hold_old)
    else $error("working address changed without status acknowledge");

  property p_copy;
    @(posedge ref_clk) disable iff (!rst_n)
      s_ack_copy |=> (active_addr == $past(bus.addr_reg[6:0])) && !pending;
  endproperty
  a_copy: assert property (p_copy)
    else $error("pending address not taken on status acknowledge");

  property p_accept;
    @(posedge ref_clk) disable iff (!rst_n)
      bus.token_valid && !active_en |=> !accept;
  endproperty
  a_accept: assert property (p_accept)
    else $error("token accepted while device disabled");
endmodule // uda_addr_unit
`default_nettype wire

// ---- rtl/uda_config_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Endpoint direction bit also gives DMA direction, 0 read, 1 write.
// - Bit 5 set gives the endpoint two alternating FIFO buffers.
// - Bit 4 high marks isochronous endpoint, low marks bulk or interrupt.
// - Bits 3 to 0 choose the FIFO size of the endpoint.
// - Bus reset sets working address to zero and enables the device.
// - Bus reset leaves the processor-visible address register untouched.
// - Old address stays in use until host acknowledges the status packet.
// - Address register written with code B6, read with B7, one word.
// - Address register bit 7 enables the device function.
// - Address register bits 6 to 0 hold the seven-bit USB address.
// - Mode register written with code B8, read with B9, one word.
// - Upper byte of a word written to the mode register is ignored.
// - Debug mode raises an interrupt on every error and every NAK.
// - Bus reset disables all endpoints; an endpoint written in the same cycle takes the written value.
// - Normal mode interrupts on bulk ACK and isochronous transfer end.
module uda_config_top
  import uda_pkg::*;
(
  input  wire logic                                ref_clk,              // 200 MHz clock.
  input  wire logic                                rst_n,                // Async reset, low.
  input  wire logic                                cmd_strobe,           // Command phase pulse.
  input  wire logic [7:0]                          cmd_code,             // Command code.
  input  wire logic                                wr_strobe,            // Data write pulse.
  input  wire logic [15:0]                         wr_data,              // Data write word.
  input  wire logic                                rd_strobe,            // Data read pulse.
  output logic      [15:0]                         rd_data,              // Read word.
  output logic                                     rd_valid,             // Read data pulse.
  input  wire logic                                usb_bus_reset,        // Bus reset pulse.
  input  wire logic                                status_ack,           // Status stage ACK.
  input  wire logic                                token_valid,          // Token seen.
  input  wire logic [6:0]                          token_addr,           // Token address.
  output logic                                     token_accept,         // Token for us.
  output logic      [6:0]                          active_address,       // Working address.
  output logic                                     active_enable,        // Working enable.
  input  wire logic                                ev_valid,             // Endpoint event.
  input  wire logic [uda_pkg::EP_IDX_W-1:0]        ev_ep,                // Event endpoint.
  input  wire logic                                ev_ack,               // ACK event.
  input  wire logic                                ev_nak,               // NAK event.
  input  wire logic                                ev_err,               // Error event.
  input  wire logic                                ev_done,              // Transfer done.
  output logic                                     ep_int,               // Interrupt pulse.
  output logic      [uda_pkg::EP_IDX_W-1:0]        ep_int_ep,            // Interrupt endpoint.
  output logic      [uda_pkg::NUM_EP-1:0]          fifo_enable,          // FIFO enables.
  output logic      [uda_pkg::NUM_EP-1:0]          endpoint_direction,   // 1 IN / DMA write.
  output logic      [uda_pkg::NUM_EP-1:0]          double_buffer_enable, // Two buffers.
  output logic      [uda_pkg::NUM_EP-1:0]          isochronous_select,   // Isochronous type.
  output logic      [uda_pkg::NUM_EP*4-1:0]        fifo_size_code,       // Size codes.
  output logic                                     debug_interrupt_mode, // Debug mode.
  output logic      [7:0]                          mode_value            // Mode register.
);
  import uda_pkg::*;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  function automatic logic ep_hit(input logic [7:0] code, input logic [7:0] base);
    ep_hit = (code[7:4] == base[7:4]);
  endfunction

  uda_addr_if addr_bus ();

  logic [7:0]          cur_cmd;
  logic [7:0]          ep_cfg [NUM_EP];
  logic [7:0]          usb_device_address;
  logic [7:0]          controller_mode_register;
  logic [15:0]         rd_word;
  logic                rd_flag;
  logic                int_flag;
  logic [EP_IDX_W-1:0] int_ep;
  logic [7:0]          next_cur_cmd;
  logic [7:0]          next_ep_cfg [NUM_EP];
  logic [7:0]          next_address;
  logic [7:0]          next_mode;
  logic [15:0]         next_rd_word;
  logic                next_rd_flag;
  logic                next_int_flag;
  logic [EP_IDX_W-1:0] next_int_ep;
  logic                addr_write;
  logic                ev_iso;

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb begin
    next_cur_cmd = cmd_strobe ? cmd_code : cur_cmd;
    next_address = usb_device_address;
    next_mode    = controller_mode_register;
    addr_write   = 1'b0;
    for (int i = 0; i < NUM_EP; i++) begin
      next_ep_cfg[i] = ep_cfg[i];
      if (usb_bus_reset) begin
        next_ep_cfg[i][EP_FIFO_EN_BIT] = 1'b0;
      end
    end
    if (usb_bus_reset) begin
      next_mode = controller_mode_register & ~MODE_BUSRST_CLR;
    end
    if (wr_strobe) begin
      if (ep_hit(cur_cmd, CMD_EP_WR_BASE)) begin
        next_ep_cfg[cur_cmd[EP_IDX_W-1:0]] = wr_data[7:0];
      end else if (cur_cmd == CMD_ADDR_WR) begin
        next_address = wr_data[7:0];
        addr_write   = 1'b1;
      end else if (cur_cmd == CMD_MODE_WR) begin
        next_mode = wr_data[7:0];
      end
    end
    next_rd_flag = rd_strobe;
    next_rd_word = rd_word;
    if (rd_strobe) begin
      next_rd_word = 16'h0000;
      if (ep_hit(cur_cmd, CMD_EP_RD_BASE)) begin
        next_rd_word = {8'h00, ep_cfg[cur_cmd[EP_IDX_W-1:0]]};
      end else if (cur_cmd == CMD_ADDR_RD) begin
        next_rd_word = {8'h00, usb_device_address};
      end else if (cur_cmd == CMD_MODE_RD) begin
        next_rd_word = {8'h00, controller_mode_register};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_cmd                  <= CMD_NONE;
      usb_device_address       <= ADDR_RST;
      controller_mode_register <= MODE_RST;
      rd_word                  <= 16'h0000;
      rd_flag                  <= 1'b0;
      for (int i = 0; i < NUM_EP; i++) begin
        ep_cfg[i] <= EP_CFG_RST;
      end
    end else begin
      cur_cmd                  <= next_cur_cmd;
      usb_device_address       <= next_address;
      controller_mode_register <= next_mode;
      rd_word                  <= next_rd_word;
      rd_flag                  <= next_rd_flag;
      for (int i = 0; i < NUM_EP; i++) begin
        ep_cfg[i] <= next_ep_cfg[i];
      end
    end
  end

  // ****************************************************************
  // Endpoint interrupt events
  // ****************************************************************
  always_comb begin
    ev_iso        = ep_cfg[ev_ep][EP_ISO_BIT];
    next_int_ep   = ev_valid ? ev_ep : int_ep;
    next_int_flag = 1'b0;
    if (ev_valid) begin
      if (controller_mode_register[MODE_DBG_BIT]) begin
        next_int_flag = ev_nak || ev_err;
      end else begin
        next_int_flag = ev_iso ? ev_done : ev_ack;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_flag <= 1'b0;
      int_ep   <= '0;
    end else begin
      int_flag <= next_int_flag;
      int_ep   <= next_int_ep;
    end
  end

  // ****************************************************************
  // Address unit
  // ****************************************************************
  assign addr_bus.addr_written = addr_write;
  // The stored value feeds the unit, so a write in an ack cycle waits for its own ack.
  assign addr_bus.addr_reg     = usb_device_address;
  assign addr_bus.bus_reset    = usb_bus_reset;
  assign addr_bus.status_ack   = status_ack;
  assign addr_bus.token_valid  = token_valid;
  assign addr_bus.token_addr   = token_addr;

  uda_addr_unit u_addr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (addr_bus.unit)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data              = rd_word;
  assign rd_valid             = rd_flag;
  assign token_accept         = addr_bus.accept;
  assign active_address       = addr_bus.active_addr;
  assign active_enable        = addr_bus.active_en;
  assign ep_int               = int_flag;
  assign ep_int_ep            = int_ep;
  assign debug_interrupt_mode = controller_mode_register[MODE_DBG_BIT];
  assign mode_value           = controller_mode_register;
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      fifo_enable[i]            = ep_cfg[i][EP_FIFO_EN_BIT];
      endpoint_direction[i]     = ep_cfg[i][EP_DIR_BIT];
      double_buffer_enable[i]   = ep_cfg[i][EP_DBL_BIT];
      isochronous_select[i]     = ep_cfg[i][EP_ISO_BIT];
      fifo_size_code[i*4 +: 4]  = ep_cfg[i][EP_SIZE_LSB +: EP_SIZE_W];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ep_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      usb_bus_reset && !wr_strobe |=> (fifo_enable == 16'h0000);
  endproperty
  a_ep_reset: assert property (p_ep_reset)
    else $error("bus reset left an endpoint enabled");

  property p_addr_kept;
    @(posedge ref_clk) disable iff (!rst_n)
      usb_bus_reset && !wr_strobe |=> $stable(usb_device_address);
  endproperty
  a_addr_kept: assert property (p_addr_kept)
    else $error("bus reset changed the address register");

  property p_addr_read;
    @(posedge ref_clk) disable iff (!rst_n)
      rd_strobe && (cur_cmd == CMD_ADDR_RD)
      |=> rd_valid && (rd_data == {8'h00, $past(usb_device_address)});
  endproperty
  a_addr_read: assert property (p_addr_read)
    else $error("address read returned wrong word");

  property p_mode_write;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_strobe && (cur_cmd == CMD_MODE_WR) |=> (mode_value == $past(wr_data[7:0]));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write did not take the low byte");

  property p_debug_int;
    @(posedge ref_clk) disable iff (!rst_n)
      ev_valid && debug_interrupt_mode && (ev_nak || ev_err) |=> ep_int && (ep_int_ep == $past(ev_ep));
  endproperty
  a_debug_int: assert property (p_debug_int)
    else $error("debug mode missed a NAK or error interrupt");

  property p_bulk_int;
    @(posedge ref_clk) disable iff (!rst_n)
      ev_valid && !debug_interrupt_mode && !ev_iso |=> (ep_int == $past(ev_ack));
  endproperty
  a_bulk_int: assert property (p_bulk_int)
    else $error("bulk ACK interrupt wrong in normal mode");

  property p_ep_write;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_strobe && (cur_cmd[7:4] == 4'h2) && !usb_bus_reset
      |=> (endpoint_direction[$past(cur_cmd[3:0])] == $past(wr_data[6]))
          && (fifo_size_code[$past(cur_cmd[3:0])*4 +: 4] == $past(wr_data[3:0]));
  endproperty
  a_ep_write: assert property (p_ep_write)
    else $error("endpoint configuration write not applied");
endmodule // uda_config_top
`default_nettype wire

// ---- tb/uda_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Upstream host: bus reset, status acknowledge and tokens.
// ****************************************************************
module uda_host_model (
  input  wire logic       ref_clk,       // System clock.
  output logic            usb_bus_reset, // Bus reset pulse.
  output logic            status_ack,    // Status stage ACK.
  output logic            token_valid,   // Token pulse.
  output logic [6:0]      token_addr     // Token address.
);
  initial begin
    usb_bus_reset = 1'b0;
    status_ack    = 1'b0;
    token_valid   = 1'b0;
    token_addr    = 7'h55;
  end

  task automatic bus_reset();
    @(posedge ref_clk);
    usb_bus_reset <= 1'b1;
    @(posedge ref_clk);
    usb_bus_reset <= 1'b0;
  endtask

  // The host acknowledges the empty status packet only after it was queued.
  task automatic ack_status();
    @(posedge ref_clk);
    status_ack <= 1'b1;
    @(posedge ref_clk);
    status_ack <= 1'b0;
  endtask

  task automatic send_token(input logic [6:0] a);
    @(posedge ref_clk);
    token_valid <= 1'b1;
    token_addr  <= a;
    @(posedge ref_clk);
    token_valid <= 1'b0;
    token_addr  <= ~a; // Idle lines must not keep showing the last address.
  endtask
endmodule // uda_host_model
`default_nettype wire

// ---- tb/usb_device_addr_ep_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_device_addr_ep_config_tb;
  import uda_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n, cmd_strobe, wr_strobe, rd_strobe, rd_valid, usb_bus_reset, status_ack;
  logic        token_valid, token_accept, active_enable, ev_valid, ev_ack, ev_nak, ev_err;
  logic        ev_done, ep_int, debug_interrupt_mode;
  logic [7:0]  cmd_code, mode_value;
  logic [15:0] wr_data, rd_data, fifo_enable, endpoint_direction;
  logic [15:0] double_buffer_enable, isochronous_select;
  logic [6:0]  token_addr, active_address;
  logic [3:0]  ev_ep, ep_int_ep;
  logic [63:0] fifo_size_code;
  int          num_errors = 0;
  int          checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  uda_config_top DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .rd_valid(rd_valid), .usb_bus_reset(usb_bus_reset), .status_ack(status_ack),
    .token_valid(token_valid), .token_addr(token_addr), .token_accept(token_accept),
    .active_address(active_address), .active_enable(active_enable), .ev_valid(ev_valid),
    .ev_ep(ev_ep), .ev_ack(ev_ack), .ev_nak(ev_nak), .ev_err(ev_err), .ev_done(ev_done),
    .ep_int(ep_int), .ep_int_ep(ep_int_ep), .fifo_enable(fifo_enable),
    .endpoint_direction(endpoint_direction), .double_buffer_enable(double_buffer_enable),
    .isochronous_select(isochronous_select), .fifo_size_code(fifo_size_code),
    .debug_interrupt_mode(debug_interrupt_mode), .mode_value(mode_value)
  );

  uda_host_model host (
    .ref_clk(ref_clk), .usb_bus_reset(usb_bus_reset), .status_ack(status_ack),
    .token_valid(token_valid), .token_addr(token_addr)
  );

  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    @(posedge ref_clk);
    cmd_strobe <= 1'b1;
    cmd_code   <= c;
    @(posedge ref_clk);
    cmd_strobe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    cmd(c);
    @(posedge ref_clk);
    wr_strobe <= 1'b1;
    wr_data   <= d;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input string name);
    cmd(c);
    @(posedge ref_clk);
    rd_strobe <= 1'b1;
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
    #1;
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk(name, exp, rd_data);
  endtask

  task automatic tok(input logic [6:0] a, input logic exp);
    host.send_token(a);
    #1;
    chk("token_accept", {15'h0000, exp}, {15'h0000, token_accept});
  endtask

  task automatic act(input logic [6:0] a, input logic en);
    chk("active_address", {9'h000, a}, {9'h000, active_address});
    chk("active_enable", {15'h0000, en}, {15'h0000, active_enable});
  endtask

  // Kind is ack, nak, err, done from high bit to low bit.
  task automatic ev(input logic [3:0] ep, input logic [3:0] kind, input logic exp);
    @(posedge ref_clk);
    ev_valid <= 1'b1;
    ev_ep    <= ep;
    {ev_ack, ev_nak, ev_err, ev_done} <= kind;
    @(posedge ref_clk);
    ev_valid <= 1'b0;
    {ev_ack, ev_nak, ev_err, ev_done} <= 4'h0;
    #1;
    chk("ep_int", {15'h0000, exp}, {15'h0000, ep_int});
    chk("ep_int_ep", {12'h000, ep}, {12'h000, ep_int_ep});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    act(7'h00, 1'b0);
    rd(CMD_ADDR_RD, 16'h0000, "addr_reg");
    rd(CMD_MODE_RD, 16'h0000, "mode_reg");
    rd(8'hC0, 16'h0000, "unmapped");
    tok(7'h00, 1'b0);
  endtask

  task automatic t_endpoints();
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {1'b1, i[2:0], i[3:0]};
      wr(CMD_EP_WR_BASE + 8'(i), {8'hA5, v});
      chk("fifo_enable", {15'h0000, v[7]}, {15'h0000, fifo_enable[i]});
      chk("ep_dir", {15'h0000, v[EP_DIR_BIT]}, {15'h0000, endpoint_direction[i]});
      chk("dbl_buf", {15'h0000, v[EP_DBL_BIT]}, {15'h0000, double_buffer_enable[i]});
      chk("iso_sel", {15'h0000, v[EP_ISO_BIT]}, {15'h0000, isochronous_select[i]});
      chk("size_code", {12'h000, v[3:0]}, {12'h000, fifo_size_code[4*i +: 4]});
      rd(CMD_EP_RD_BASE + 8'(i), {8'h00, v}, "ep_cfg");
    end
  endtask

  task automatic t_address();
    wr(CMD_ADDR_WR, 16'hFF85);
    rd(CMD_ADDR_RD, 16'h0085, "addr_reg");
    act(7'h00, 1'b0);
    tok(7'h05, 1'b0);
    host.ack_status();
    #1;
    act(7'h05, 1'b1);
    tok(7'h05, 1'b1);
    tok(7'h06, 1'b0);
    host.ack_status();
    #1;
    act(7'h05, 1'b1);
    wr(CMD_ADDR_WR, 16'h0012);
    host.ack_status();
    #1;
    act(7'h12, 1'b0);
    tok(7'h12, 1'b0);
  endtask

  task automatic t_bus_reset();
    wr(CMD_MODE_WR, 16'hAB77);
    rd(CMD_MODE_RD, 16'h0077, "mode_reg");
    chk("mode_value", 16'h0077, {8'h00, mode_value});
    chk("debug_mode", 16'h0001, {15'h0000, debug_interrupt_mode});
    host.bus_reset();
    #1;
    act(7'h00, 1'b1);
    chk("fifo_enable", 16'h0000, fifo_enable);
    rd(CMD_ADDR_RD, 16'h0012, "addr_reg");
    rd(CMD_MODE_RD, 16'h0007, "mode_reg");
    tok(7'h00, 1'b1);
    wr(CMD_ADDR_WR, 16'h0099);
    host.bus_reset();
    host.ack_status();
    #1;
    act(7'h00, 1'b1);
  endtask

  task automatic t_events();
    ev(4'h3, 4'h4, 1'b1);
    ev(4'h3, 4'h2, 1'b1);
    ev(4'h3, 4'h8, 1'b0);
    wr(CMD_MODE_WR, 16'h0000);
    ev(4'h2, 4'h8, 1'b1);
    ev(4'h2, 4'h1, 1'b0);
    ev(4'h3, 4'h1, 1'b1);
    ev(4'h3, 4'h8, 1'b0);
    ev(4'h2, 4'h4, 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    for (int n = 0; n < 20000; n++) begin
      @(posedge ref_clk);
    end
    num_errors++;
    print_verdict();
  end

  initial begin
    rst_n      = 1'b0;
    cmd_strobe = 1'b0;
    cmd_code   = 8'h00;
    wr_strobe  = 1'b0;
    wr_data    = 16'h0000;
    rd_strobe  = 1'b0;
    ev_valid   = 1'b0;
    ev_ep      = 4'h0;
    {ev_ack, ev_nak, ev_err, ev_done} = 4'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_endpoints();
    t_address();
    t_bus_reset();
    t_events();
    print_verdict();
  end
endmodule // usb_device_addr_ep_config_tb
`default_nettype wire
